// ===== page_xlate_pkg.sv
// Constants shared by the page translation unit and its TLB
// How it works
// - Control flags choose off, 4K or 4M mapping
// - Linear bits 31:22 index the directory
// - Linear bits 21:12 index the page table
// - Small page keeps bits 11:0 as offset
// - Large directory entry gives page base directly
// - Large page keeps bits 21:0 as offset
// - Large only if enable and size flag set
// - Enable clear forces table walk, flag ignored
// - Mixed entry kinds decided per directory entry
// - Separate TLBs for large and small pages
// - Directory base register roots every walk
// - Directory base has no presence check
// - Table entry gives top 20 address bits
// - Translation enable is control zero bit 31
// - Large-page enable is control four bit 4
// - Directory entry size flag is bit 7
// - Clear resident bit 0 faults the access
package page_xlate_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_ZERO  = 8'h00;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h04;
  localparam logic [7:0] OFS_CTRL_FOUR  = 8'h08;
  localparam logic [7:0] OFS_FLUSH      = 8'h0C;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;

  // Reset values
  localparam logic [31:0] RST_CTRL_ZERO  = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL_THREE = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL_FOUR  = 32'h0000_0000;

  // Control field positions
  localparam int TE_BIT  = 31;
  localparam int BPE_BIT = 4;
  localparam int EPA_BIT = 5;

  // Entry field positions
  localparam int PRESENT_BIT   = 0;
  localparam int PAGE_SIZE_BIT = 7;

  // Linear address split
  localparam int DIR_HI  = 31;
  localparam int DIR_LO  = 22;
  localparam int TBL_HI  = 21;
  localparam int TBL_LO  = 12;
  localparam int OFS_HI  = 11;
  localparam int BIG_HI  = 21;

  // Status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CNT_LO   = 16;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== xlate_tlb.sv
// Small fully associative translation cache with round-robin refill
`timescale 1ns/1ps
module xlate_tlb
  import page_xlate_pkg::*;
#(
  parameter int ENTRIES = 8,
  parameter int TAG_W   = 20,
  parameter int DATA_W  = 20
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Invalidate all entries
  input  wire logic              flush,
  // Lookup
  input  wire logic [TAG_W-1:0]  look_tag,
  output logic                   hit,
  output logic [DATA_W-1:0]      hit_data,
  // Refill
  input  wire logic              fill,
  input  wire logic [TAG_W-1:0]  fill_tag,
  input  wire logic [DATA_W-1:0] fill_data
);

  localparam int PTR_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  logic [ENTRIES-1:0] valid;
  logic [TAG_W-1:0]   tags  [ENTRIES];
  logic [DATA_W-1:0]  datas [ENTRIES];
  logic [PTR_W-1:0]   victim;

  always_comb begin
    hit      = 1'b0;
    hit_data = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (valid[i] && tags[i] == look_tag) begin
        hit      = 1'b1;
        hit_data = datas[i];
      end
    end
  end

  // Flush wins over a refill in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid  <= '0;
      victim <= '0;
    end else if (flush) begin
      valid  <= '0;
    end else if (fill) begin
      valid[victim] <= 1'b1;
      victim        <= (victim == PTR_W'(ENTRIES - 1)) ? '0 : victim + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (fill) begin
      tags[victim]  <= fill_tag;
      datas[victim] <= fill_data;
    end
  end

endmodule

// ===== linear_page_translation_32.sv
// Two-level linear to physical page translation unit with AXI4-Lite control
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module linear_page_translation_32
  import page_xlate_pkg::*;
#(
  parameter int SMALL_ENTRIES = 8,
  parameter int LARGE_ENTRIES = 4
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Translation request
  input  wire logic        req_valid,
  input  wire logic [31:0] req_laddr,
  output logic             req_ready,
  // Translation answer
  output logic             resp_valid,
  output logic [31:0]      resp_paddr,
  output logic             resp_fault,
  output logic             resp_large,
  // Table memory read port
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);

  typedef enum {
    ST_IDLE,
    ST_LOOKUP,
    ST_DIR_WAIT,
    ST_TBL_WAIT
  } walk_state_type;

  walk_state_type state;

  // Software visible state
  logic [31:0] ctrl_reg_zero;
  logic [31:0] ctrl_reg_three;
  logic [31:0] ctrl_reg_four;
  logic [31:0] fault_laddr;
  logic [15:0] fault_count;
  logic        tlb_flush;

  // Bus slave state
  logic        aw_held;
  logic        w_held;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;

  // Walk state
  logic [31:0] lin_q;
  logic        fault_evt;
  logic        small_fill;
  logic [19:0] small_fill_tag;
  logic [19:0] small_fill_data;
  logic        large_fill;
  logic [9:0]  large_fill_tag;
  logic [9:0]  large_fill_data;

  // TLB lookups
  logic        small_hit;
  logic [19:0] small_frame;
  logic        large_hit;
  logic [9:0]  large_frame;

  // Mode flags
  logic        translation_enable;
  logic        big_page_enable;
  logic        extended_phys_addr_enable;
  logic [19:0] dir_base_register;

  assign translation_enable        = ctrl_reg_zero[TE_BIT];
  assign big_page_enable           = ctrl_reg_four[BPE_BIT];
  assign extended_phys_addr_enable = ctrl_reg_four[EPA_BIT];
  assign dir_base_register         = ctrl_reg_three[31:TBL_LO];

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address of a 32-bit entry inside a 4K-aligned table
  function automatic logic [31:0] entry_addr(input logic [19:0] base,
                                             input logic [9:0]  idx);
    return {base, idx, 2'b00};
  endfunction

  function automatic logic reg_mapped(input logic [7:0] addr);
    case (addr)
      OFS_CTRL_ZERO,
      OFS_CTRL_THREE,
      OFS_CTRL_FOUR,
      OFS_FLUSH,
      OFS_FAULT_ADDR,
      OFS_STATUS: return 1'b1;
      default:    return 1'b0;
    endcase
  endfunction

  // Write address channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      awaddr_q      <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_held) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held       <= 1'b0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_held) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Write response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; a new directory root also drops cached translations
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg_zero  <= RST_CTRL_ZERO;
      ctrl_reg_three <= RST_CTRL_THREE;
      ctrl_reg_four  <= RST_CTRL_FOUR;
      tlb_flush      <= 1'b0;
    end else begin
      tlb_flush <= 1'b0;
      if (do_write) begin
        case (awaddr_q)
          OFS_CTRL_ZERO: ctrl_reg_zero <= merge_bytes(ctrl_reg_zero, wdata_q, wstrb_q);
          OFS_CTRL_THREE: begin
            ctrl_reg_three <= merge_bytes(ctrl_reg_three, wdata_q, wstrb_q);
            tlb_flush      <= 1'b1;
          end
          OFS_CTRL_FOUR: ctrl_reg_four <= merge_bytes(ctrl_reg_four, wdata_q, wstrb_q);
          OFS_FLUSH:     tlb_flush     <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Read channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_CTRL_ZERO:  s_axi_rdata <= ctrl_reg_zero;
        OFS_CTRL_THREE: s_axi_rdata <= ctrl_reg_three;
        OFS_CTRL_FOUR:  s_axi_rdata <= ctrl_reg_four;
        OFS_FAULT_ADDR: s_axi_rdata <= fault_laddr;
        OFS_STATUS: begin
          s_axi_rdata                <= 32'h0000_0000;
          s_axi_rdata[31:STAT_CNT_LO] <= fault_count;
          s_axi_rdata[STAT_BUSY_BIT] <= (state != ST_IDLE);
        end
        default:        s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Small and large pages never share entries
  xlate_tlb #(
    .ENTRIES (SMALL_ENTRIES),
    .TAG_W   (20),
    .DATA_W  (20)
  ) small_tlb (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .flush     (tlb_flush),
    .look_tag  (lin_q[DIR_HI:TBL_LO]),
    .hit       (small_hit),
    .hit_data  (small_frame),
    .fill      (small_fill),
    .fill_tag  (small_fill_tag),
    .fill_data (small_fill_data)
  );

  xlate_tlb #(
    .ENTRIES (LARGE_ENTRIES),
    .TAG_W   (10),
    .DATA_W  (10)
  ) large_tlb (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .flush     (tlb_flush),
    .look_tag  (lin_q[DIR_HI:DIR_LO]),
    .hit       (large_hit),
    .hit_data  (large_frame),
    .fill      (large_fill),
    .fill_tag  (large_fill_tag),
    .fill_data (large_fill_data)
  );

  // Walk engine: one translation in flight, answer is a single-cycle pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state           <= ST_IDLE;
      lin_q           <= 32'h0000_0000;
      req_ready       <= 1'b0;
      resp_valid      <= 1'b0;
      resp_paddr      <= 32'h0000_0000;
      resp_fault      <= 1'b0;
      resp_large      <= 1'b0;
      mem_req         <= 1'b0;
      mem_addr        <= 32'h0000_0000;
      fault_evt       <= 1'b0;
      small_fill      <= 1'b0;
      small_fill_tag  <= 20'h00000;
      small_fill_data <= 20'h00000;
      large_fill      <= 1'b0;
      large_fill_tag  <= 10'h000;
      large_fill_data <= 10'h000;
    end else begin
      resp_valid <= 1'b0;
      fault_evt  <= 1'b0;
      small_fill <= 1'b0;
      large_fill <= 1'b0;
      case (state)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            lin_q     <= req_laddr;
            state     <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          state      <= ST_IDLE;
          resp_fault <= 1'b0;
          resp_large <= 1'b0;
          if (!translation_enable) begin
            resp_valid <= 1'b1;
            resp_paddr <= lin_q;
          end else if (extended_phys_addr_enable) begin
            // Wide physical modes are not built here; refuse as a fault
            resp_valid <= 1'b1;
            resp_paddr <= 32'h0000_0000;
            resp_fault <= 1'b1;
            fault_evt  <= 1'b1;
          end else if (big_page_enable && large_hit) begin
            resp_valid <= 1'b1;
            resp_large <= 1'b1;
            resp_paddr <= {large_frame, lin_q[BIG_HI:0]};
          end else if (small_hit) begin
            resp_valid <= 1'b1;
            resp_paddr <= {small_frame, lin_q[OFS_HI:0]};
          end else begin
            // Directory assumed resident: base register has no presence bit
            mem_req  <= 1'b1;
            mem_addr <= entry_addr(dir_base_register, lin_q[DIR_HI:DIR_LO]);
            state    <= ST_DIR_WAIT;
          end
        end
        ST_DIR_WAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            if (!mem_rdata[PRESENT_BIT]) begin
              resp_valid <= 1'b1;
              resp_paddr <= 32'h0000_0000;
              resp_fault <= 1'b1;
              fault_evt  <= 1'b1;
              state      <= ST_IDLE;
            end else if (big_page_enable && mem_rdata[PAGE_SIZE_BIT]) begin
              resp_valid      <= 1'b1;
              resp_large      <= 1'b1;
              resp_paddr      <= {mem_rdata[DIR_HI:DIR_LO], lin_q[BIG_HI:0]};
              large_fill      <= 1'b1;
              large_fill_tag  <= lin_q[DIR_HI:DIR_LO];
              large_fill_data <= mem_rdata[DIR_HI:DIR_LO];
              state           <= ST_IDLE;
            end else begin
              // Size flag ignored unless large pages are enabled
              mem_req  <= 1'b1;
              mem_addr <= entry_addr(mem_rdata[31:TBL_LO], lin_q[TBL_HI:TBL_LO]);
              state    <= ST_TBL_WAIT;
            end
          end
        end
        ST_TBL_WAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            state   <= ST_IDLE;
            if (!mem_rdata[PRESENT_BIT]) begin
              resp_valid <= 1'b1;
              resp_paddr <= 32'h0000_0000;
              resp_fault <= 1'b1;
              fault_evt  <= 1'b1;
            end else begin
              resp_valid      <= 1'b1;
              resp_paddr      <= {mem_rdata[31:TBL_LO], lin_q[OFS_HI:0]};
              small_fill      <= 1'b1;
              small_fill_tag  <= lin_q[DIR_HI:TBL_LO];
              small_fill_data <= mem_rdata[31:TBL_LO];
            end
          end
        end
        default: begin
          state   <= ST_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  // Fault log; the counter saturates rather than wrapping to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_laddr <= 32'h0000_0000;
      fault_count <= 16'h0000;
    end else if (fault_evt) begin
      fault_laddr <= lin_q;
      if (fault_count != 16'hFFFF) begin
        fault_count <= fault_count + 16'h0001;
      end
    end
  end

endmodule

// ===== linear_page_translation_32_assertions.sv
// Port checker for the page translation unit
`timescale 1ns/1ps
module linear_page_translation_32_assertions
  import page_xlate_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Translation
  input wire logic        req_valid,
  input wire logic [31:0] req_laddr,
  input wire logic        req_ready,
  input wire logic        resp_valid,
  input wire logic [31:0] resp_paddr,
  input wire logic        resp_fault,
  input wire logic        resp_large,
  // Table memory
  input wire logic        mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata
);
  logic [31:0] la;
  logic        dir_phase;
  logic [31:0] ent;
  // Answers come cycles later, so keep the address and last entry
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      la        <= 32'h0;
      dir_phase <= 1'b0;
      ent       <= 32'h0;
    end else begin
      if (req_valid && req_ready) begin
        la        <= req_laddr;
        dir_phase <= 1'b1;
      end else if (mem_ack) begin
        dir_phase <= 1'b0;
      end
      if (mem_ack) begin
        ent <= mem_rdata;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_dir_ack; mem_ack && dir_phase; endsequence
  property p_align; mem_req |-> mem_addr[1:0] == 2'h0; endproperty
  a_align: assert property (p_align) else $error("entry address not aligned");
  property p_dir_idx; mem_req && dir_phase |-> mem_addr[11:2] == la[31:22]; endproperty
  a_dir_idx: assert property (p_dir_idx) else $error("directory index wrong");
  property p_tbl_addr;
    s_dir_ack ##0 mem_rdata[0] && !mem_rdata[7] |=> mem_req && mem_addr == {ent[31:12], la[21:12], 2'h0};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table entry address wrong");
  property p_fault; mem_ack && !mem_rdata[0] |=> resp_valid && resp_fault && resp_paddr == 32'h0; endproperty
  a_fault: assert property (p_fault) else $error("absent entry not faulted");
  property p_small;
    mem_ack && !dir_phase && mem_rdata[0] |=> resp_valid && !resp_fault && !resp_large
      && resp_paddr == {ent[31:12], la[11:0]};
  endproperty
  a_small: assert property (p_small) else $error("small page address wrong");
  property p_large;
    s_dir_ack ##0 mem_rdata[0] && mem_rdata[7] |=> (resp_valid && resp_large
      && resp_paddr == {ent[31:22], la[21:0]}) || (mem_req && !resp_valid);
  endproperty
  a_large: assert property (p_large) else $error("large page address wrong");
  property p_big_ofs; resp_valid && resp_large && !resp_fault |-> resp_paddr[21:0] == la[21:0]; endproperty
  a_big_ofs: assert property (p_big_ofs) else $error("large page offset altered");
  property p_busy; s_take |=> !req_ready until resp_valid; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_answer; s_take |-> ##[2:600] resp_valid; endproperty
  a_answer: assert property (p_answer) else $error("no answer in time");
  property p_pulse; resp_valid |=> $fell(resp_valid) && req_ready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer not one pulse");
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("table read dropped");
endmodule

bind linear_page_translation_32 linear_page_translation_32_assertions i_chk (
  .ref_clk, .rst_n, .req_valid, .req_laddr, .req_ready, .resp_valid, .resp_paddr,
  .resp_fault, .resp_large, .mem_req, .mem_addr, .mem_ack, .mem_rdata
);

// ===== table_mem_model.sv
// Behavioural table memory answering the unit's entry reads
`timescale 1ns/1ps
module table_mem_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Read port
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // Extra wait cycles
  input  wire logic [3:0]  delay
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0]  wait_cnt;
  int          n_reads;
  // Data scrambles outside the ack cycle so stale reads show
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_cnt  <= 4'h0;
      n_reads   <= 0;
    end else if (mem_req && !mem_ack && wait_cnt >= delay) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0;
      wait_cnt  <= 4'h0;
      n_reads   <= n_reads + 1;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== linear_page_translation_32_tb_top.sv
// Self-checking bench for the page translation unit
`timescale 1ns/1ps
module linear_page_translation_32_tb_top;
  import page_xlate_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, req_laddr = 32'h0, resp_paddr, mem_addr, mem_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, delay = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, req_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic req_ready, resp_valid, resp_fault, resp_large, mem_req, mem_ack;
  int mismatches = 0;
  int n_compared = 0;

  always #2.5 ref_clk = ~ref_clk;

  linear_page_translation_32 #(.SMALL_ENTRIES(8), .LARGE_ENTRIES(4)) i_linear_page_translation_32 (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .req_valid, .req_laddr, .req_ready, .resp_valid, .resp_paddr, .resp_fault, .resp_large,
    .mem_req, .mem_addr, .mem_ack, .mem_rdata);
  table_mem_model i_table_mem_model (.ref_clk, .rst_n, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .delay);

  task automatic close_out();
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, r);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, d);
    check(s_axi_rresp, r);
  endtask

  // Large flag only checked on good answers; its value on a fault is open
  task automatic xl(input logic [31:0] la, input logic [31:0] pa, input logic f, input logic lg,
                    input int nr);
    int n0;
    n0 = i_table_mem_model.n_reads;
    @(posedge ref_clk);
    req_laddr <= la;
    req_valid <= 1'b1;
    do @(posedge ref_clk); while (!req_ready);
    req_valid <= 1'b0;
    do @(posedge ref_clk); while (!resp_valid);
    check(resp_paddr, pa);
    check(resp_fault, f);
    if (!f) check(resp_large, lg);
    check(32'(i_table_mem_model.n_reads - n0), 32'(nr));
  endtask

  initial begin
    i_table_mem_model.mem[32'h0010_0004] = 32'h0C00_0081;
    i_table_mem_model.mem[32'h0C00_000C] = 32'hABCD_E001;
    i_table_mem_model.mem[32'h0010_0008] = 32'h0D00_0001;
    i_table_mem_model.mem[32'h0D00_0004] = 32'h1234_5001;
    i_table_mem_model.mem[32'h0010_0010] = 32'h0E00_0001;
    i_table_mem_model.mem[32'h0030_0004] = 32'h0F00_0081;
    i_table_mem_model.mem[32'h0F00_000C] = 32'h5555_5001;
    i_table_mem_model.mem[32'h0010_0014] = 32'h0D00_0001;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    axi_rd(OFS_CTRL_ZERO, RST_CTRL_ZERO, RESP_OKAY);
    axi_rd(OFS_CTRL_THREE, RST_CTRL_THREE, RESP_OKAY);
    axi_rd(OFS_CTRL_FOUR, RST_CTRL_FOUR, RESP_OKAY);
    axi_rd(8'h18, 32'h0, RESP_SLVERR);
    axi_wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    axi_rd(OFS_STATUS, 32'h0, RESP_OKAY);
    xl(32'h1234_5678, 32'h1234_5678, 1'b0, 1'b0, 0);
    axi_wr(OFS_CTRL_THREE, 32'h0010_0000, RESP_OKAY);
    s_axi_wstrb <= 4'h8;
    axi_wr(OFS_CTRL_ZERO, 32'hFFFF_FFFF, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(OFS_CTRL_ZERO, 32'hFF00_0000, RESP_OKAY);
    xl(32'h0040_3ABC, 32'hABCD_EABC, 1'b0, 1'b0, 2);
    xl(32'h0040_3123, 32'hABCD_E123, 1'b0, 1'b0, 0);
    delay <= 4'h4;
    axi_wr(OFS_CTRL_FOUR, 32'h1 << BPE_BIT, RESP_OKAY);
    axi_wr(OFS_FLUSH, 32'h0, RESP_OKAY);
    xl(32'h0040_3ABC, 32'h0C00_3ABC, 1'b0, 1'b1, 1);
    xl(32'h0080_1FFF, 32'h1234_5FFF, 1'b0, 1'b0, 2);
    xl(32'h0040_0000, 32'h0C00_0000, 1'b0, 1'b1, 0);
    xl(32'h0080_1000, 32'h1234_5000, 1'b0, 1'b0, 0);
    xl(32'h0140_1234, 32'h1234_5234, 1'b0, 1'b0, 2);
    delay <= 4'h0;
    xl(32'h00C0_0000, 32'h0, 1'b1, 1'b0, 1);
    xl(32'h0100_0000, 32'h0, 1'b1, 1'b0, 2);
    axi_rd(OFS_FAULT_ADDR, 32'h0100_0000, RESP_OKAY);
    axi_rd(OFS_STATUS, 32'h2 << STAT_CNT_LO, RESP_OKAY);
    axi_wr(OFS_CTRL_FOUR, (32'h1 << BPE_BIT) | (32'h1 << EPA_BIT), RESP_OKAY);
    xl(32'h0040_3ABC, 32'h0, 1'b1, 1'b0, 0);
    axi_wr(OFS_CTRL_FOUR, 32'h1 << BPE_BIT, RESP_OKAY);
    axi_wr(OFS_CTRL_THREE, 32'h0030_0000, RESP_OKAY);
    xl(32'h0040_3ABC, 32'h0F00_3ABC, 1'b0, 1'b1, 1);
    axi_wr(OFS_CTRL_FOUR, 32'h0, RESP_OKAY);
    axi_wr(OFS_FLUSH, 32'h0, RESP_OKAY);
    xl(32'h0040_3ABC, 32'h5555_5ABC, 1'b0, 1'b0, 2);
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #25000;
    mismatches++;
    close_out();
  end
endmodule
